/* File: rtl/spfa_pkg.sv */
// Shared constants and types for the shared pin function arbiter
package spfa_pkg;

  // Pad count and register bus widths
  localparam int NUM_PADS = 8;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFF_PORT_DATA    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIR     = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PULL_EN      = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_EXT_INT_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_OWNER_LO     = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_OWNER_HI     = 4'h5;

  // Reset values: inputs, no pulls, buffers off
  localparam logic [DATA_W-1:0] RST_PORT_DATA    = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_DIR     = 8'h00;
  localparam logic [DATA_W-1:0] RST_PULL_EN      = 8'h00;
  localparam logic [DATA_W-1:0] RST_EXT_INT_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_PAD_OE_N     = 8'hff;
  localparam logic [DATA_W-1:0] RST_ZERO         = 8'h00;
  localparam logic              RST_BIT          = 1'b0;

  // External interrupt control fields
  localparam int                EXT_EN_BIT    = 0;
  localparam int                EXT_RISE_BIT  = 1;
  localparam int                EXT_PULL_BIT  = 2;
  localparam logic [DATA_W-1:0] EXT_CTRL_MASK = 8'h07;

  // Pads 0..3 are port_d_bit_seven, port_d_bit_three, port_d_bit_two, port_g_bit_four
  localparam logic [NUM_PADS-1:0] KEYPAD_PAD_MASK = 8'h0f;

  // Owner of a pad
  typedef enum logic [1:0] {
    OWN_PORT = 2'b00,
    OWN_LO   = 2'b01,
    OWN_HI   = 2'b10
  } spfa_owner_e;

endpackage

/* File: rtl/spfa_pad_if.sv */
// Carrier between the arbiter top and its owner selection logic
`timescale 1ns/10ps
interface spfa_pad_if;
  logic [spfa_pkg::NUM_PADS-1:0] port_dir;
  logic [spfa_pkg::NUM_PADS-1:0] port_out;
  logic [spfa_pkg::NUM_PADS-1:0] pull_en;
  logic [spfa_pkg::NUM_PADS-1:0] lo_en;
  logic [spfa_pkg::NUM_PADS-1:0] lo_oe;
  logic [spfa_pkg::NUM_PADS-1:0] lo_out;
  logic [spfa_pkg::NUM_PADS-1:0] hi_en;
  logic [spfa_pkg::NUM_PADS-1:0] hi_oe;
  logic [spfa_pkg::NUM_PADS-1:0] hi_out;
  logic [spfa_pkg::NUM_PADS-1:0] rise_sense;
  logic [spfa_pkg::NUM_PADS-1:0] drive;
  logic [spfa_pkg::NUM_PADS-1:0] value;
  logic [spfa_pkg::NUM_PADS-1:0] pull_up;
  logic [spfa_pkg::NUM_PADS-1:0] pull_down;
  spfa_pkg::spfa_owner_e         owner [spfa_pkg::NUM_PADS];

  modport sel (
    input  port_dir, port_out, pull_en, lo_en, lo_oe, lo_out,
    input  hi_en, hi_oe, hi_out, rise_sense,
    output drive, value, pull_up, pull_down, owner
  );

  modport top (
    output port_dir, port_out, pull_en, lo_en, lo_oe, lo_out,
    output hi_en, hi_oe, hi_out, rise_sense,
    input  drive, value, pull_up, pull_down, owner
  );
endinterface

/* File: rtl/spfa_owner_sel.sv */
// Per-pad owner selection, buffer enable, output value and pull selection
`timescale 1ns/10ps
module spfa_owner_sel (
  // Pad configuration in, pad control out
  spfa_pad_if.sel pads
);

  genvar g;

  // One identical slice per pad
  generate
    for (g = 0; g < spfa_pkg::NUM_PADS; g++) begin : g_pad
      wire keypad_rise;
      wire pull_on;

      // Higher alternate beats lower alternate, port is last
      assign pads.owner[g] = pads.hi_en[g] ? spfa_pkg::OWN_HI :
                             pads.lo_en[g] ? spfa_pkg::OWN_LO : spfa_pkg::OWN_PORT;

      // Owning peripheral drives the buffer enable over the port direction
      assign pads.drive[g] = (pads.owner[g] == spfa_pkg::OWN_HI) ? pads.hi_oe[g] :
                             (pads.owner[g] == spfa_pkg::OWN_LO) ? pads.lo_oe[g] :
                             pads.port_dir[g];
      assign pads.value[g] = (pads.owner[g] == spfa_pkg::OWN_HI) ? pads.hi_out[g] :
                             (pads.owner[g] == spfa_pkg::OWN_LO) ? pads.lo_out[g] :
                             pads.port_out[g];

      // Keypad ownership with rising sense flips the pull to a pulldown
      assign keypad_rise = spfa_pkg::KEYPAD_PAD_MASK[g] &&
                           (pads.owner[g] == spfa_pkg::OWN_LO) && pads.rise_sense[g];

      // Pull applies whenever the pad acts as an input, whoever owns it
      assign pull_on           = pads.pull_en[g] && !pads.drive[g];
      assign pads.pull_up[g]   = pull_on && !keypad_rise;
      assign pads.pull_down[g] = pull_on && keypad_rise;
    end
  endgenerate

endmodule

/* File: rtl/spfa_top.sv */
// Shared pin function arbiter: pad ownership, pulls, port reads, external interrupt pin
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// Overview of operation
// - External interrupt pad feeds interrupt logic and both pin-level branch conditions.
// - With external interrupt disabled the pad gives no request, no level, no pull.
// - External interrupt enabled with rising edge sense selects pulldown instead of pullup.
// - After reset every shared pad is an input, buffer off, pulls off.
// - An owning peripheral sets pad direction through the output buffer enable.
// - Port data reads follow the direction bit, even under peripheral ownership.
// - Pull enable applies whenever the pad is an input, any owner.
// - Keypad pads owned by keypad module with rising sense get pulldown.
// - Several enabled functions on a pad: highest fixed priority wins.
module spfa_top (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_sys_rst,
  // Register port
  input  wire logic [spfa_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic [spfa_pkg::DATA_W-1:0]   i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [spfa_pkg::DATA_W-1:0]   o_reg_rdata,
  // Shared pads
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_pad_in,
  output logic      [spfa_pkg::NUM_PADS-1:0] o_pad_out,
  output logic      [spfa_pkg::NUM_PADS-1:0] o_pad_oe_n,
  output logic      [spfa_pkg::NUM_PADS-1:0] o_pad_pullup,
  output logic      [spfa_pkg::NUM_PADS-1:0] o_pad_pulldown,
  // Peripherals: lower priority alternate function
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_lo_en,
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_lo_oe,
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_lo_out,
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_keypad_rise_sense,
  // Peripherals: higher priority alternate function
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_hi_en,
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_hi_oe,
  input  wire logic [spfa_pkg::NUM_PADS-1:0] i_alt_hi_out,
  // Synchronised pad levels to the peripherals
  output logic      [spfa_pkg::NUM_PADS-1:0] o_pad_level,
  // External interrupt pin
  input  wire logic                          i_ext_int_pad,
  output logic                               o_ext_int_req_level,
  output logic                               o_branch_if_int_pin_high,
  output logic                               o_branch_if_int_pin_low,
  output logic                               o_ext_int_pullup,
  output logic                               o_ext_int_pulldown
);

  // Software registers
  logic [spfa_pkg::DATA_W-1:0]   port_data;
  logic [spfa_pkg::DATA_W-1:0]   port_dir;
  logic [spfa_pkg::DATA_W-1:0]   pull_en;
  logic [spfa_pkg::DATA_W-1:0]   ext_ctrl;

  // Pad input synchronisers
  logic [spfa_pkg::NUM_PADS-1:0] pad_s1;
  logic [spfa_pkg::NUM_PADS-1:0] pad_s2;
  logic                          ext_s1;
  logic                          ext_s2;

  // Decode and selection wires
  wire                           wr_data;
  wire                           wr_dir;
  wire                           wr_pull;
  wire                           wr_ext;
  wire [spfa_pkg::DATA_W-1:0]    port_read;
  wire [spfa_pkg::NUM_PADS-1:0]  owner_lo;
  wire [spfa_pkg::NUM_PADS-1:0]  owner_hi;
  wire [spfa_pkg::DATA_W-1:0]    next_rdata;
  wire                           ext_en;
  wire                           ext_rise;
  wire                           ext_pull;
  wire                           next_ext_pullup;
  wire                           next_ext_pulldown;

  // Pad control carrier
  spfa_pad_if pif ();

  // Owner selection for all pads
  spfa_owner_sel spfa_owner_sel_inst (
    .pads (pif.sel)
  );

  // Feed configuration to the owner selection
  assign pif.port_dir   = port_dir;
  assign pif.port_out   = port_data;
  assign pif.pull_en    = pull_en;
  assign pif.lo_en      = i_alt_lo_en;
  assign pif.lo_oe      = i_alt_lo_oe;
  assign pif.lo_out     = i_alt_lo_out;
  assign pif.hi_en      = i_alt_hi_en;
  assign pif.hi_oe      = i_alt_hi_oe;
  assign pif.hi_out     = i_alt_hi_out;
  assign pif.rise_sense = i_keypad_rise_sense;

  // Write decode
  assign wr_data = i_reg_wr && (i_reg_addr == spfa_pkg::OFF_PORT_DATA);
  assign wr_dir  = i_reg_wr && (i_reg_addr == spfa_pkg::OFF_PORT_DIR);
  assign wr_pull = i_reg_wr && (i_reg_addr == spfa_pkg::OFF_PULL_EN);
  assign wr_ext  = i_reg_wr && (i_reg_addr == spfa_pkg::OFF_EXT_INT_CTRL);

  // Port read: output latch where direction is out, pad level where in
  assign port_read = (port_dir & port_data) | (~port_dir & pad_s2);

  // Owner status bits per pad
  genvar g;
  generate
    for (g = 0; g < spfa_pkg::NUM_PADS; g++) begin : g_owner
      assign owner_lo[g] = (pif.owner[g] == spfa_pkg::OWN_LO);
      assign owner_hi[g] = (pif.owner[g] == spfa_pkg::OWN_HI);
    end
  endgenerate

  // Read select; unmapped offsets read as zero
  assign next_rdata =
    (i_reg_addr == spfa_pkg::OFF_PORT_DATA)    ? port_read :
    (i_reg_addr == spfa_pkg::OFF_PORT_DIR)     ? port_dir  :
    (i_reg_addr == spfa_pkg::OFF_PULL_EN)      ? pull_en   :
    (i_reg_addr == spfa_pkg::OFF_EXT_INT_CTRL) ? ext_ctrl  :
    (i_reg_addr == spfa_pkg::OFF_OWNER_LO)     ? owner_lo  :
    (i_reg_addr == spfa_pkg::OFF_OWNER_HI)     ? owner_hi  : spfa_pkg::RST_ZERO;

  // External interrupt control fields
  assign ext_en   = ext_ctrl[spfa_pkg::EXT_EN_BIT];
  assign ext_rise = ext_ctrl[spfa_pkg::EXT_RISE_BIT];
  assign ext_pull = ext_ctrl[spfa_pkg::EXT_PULL_BIT];

  // Rising sense swaps the pin pull to a pulldown; disabled pin has no pull
  assign next_ext_pullup   = ext_en && ext_pull && !ext_rise;
  assign next_ext_pulldown = ext_en && ext_pull && ext_rise;

  // Software registers; reset leaves every pad an unpulled input
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      port_data <= spfa_pkg::RST_PORT_DATA;
      port_dir  <= spfa_pkg::RST_PORT_DIR;
      pull_en   <= spfa_pkg::RST_PULL_EN;
      ext_ctrl  <= spfa_pkg::RST_EXT_INT_CTRL;
    end else begin
      if (wr_data) port_data <= i_reg_wdata;
      if (wr_dir)  port_dir  <= i_reg_wdata;
      if (wr_pull) pull_en   <= i_reg_wdata;
      if (wr_ext)  ext_ctrl  <= i_reg_wdata & spfa_pkg::EXT_CTRL_MASK;
    end
  end

  // Two-stage synchronisers on all pad inputs
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pad_s1 <= spfa_pkg::RST_ZERO;
      pad_s2 <= spfa_pkg::RST_ZERO;
      ext_s1 <= spfa_pkg::RST_BIT;
      ext_s2 <= spfa_pkg::RST_BIT;
    end else begin
      pad_s1 <= i_pad_in;
      pad_s2 <= pad_s1;
      ext_s1 <= i_ext_int_pad;
      ext_s2 <= ext_s1;
    end
  end

  // Read data stands one cycle after the read strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= spfa_pkg::RST_ZERO;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : spfa_pkg::RST_ZERO;
    end
  end

  // Registered pad controls; enable is active low
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_pad_oe_n     <= spfa_pkg::RST_PAD_OE_N;
      o_pad_out      <= spfa_pkg::RST_ZERO;
      o_pad_pullup   <= spfa_pkg::RST_ZERO;
      o_pad_pulldown <= spfa_pkg::RST_ZERO;
      o_pad_level    <= spfa_pkg::RST_ZERO;
    end else begin
      o_pad_oe_n     <= ~pif.drive;
      o_pad_out      <= pif.value;
      o_pad_pullup   <= pif.pull_up;
      o_pad_pulldown <= pif.pull_down;
      o_pad_level    <= pad_s2;
    end
  end

  // Pin level to interrupt logic and branch conditions, all gated by enable
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_ext_int_req_level      <= spfa_pkg::RST_BIT;
      o_branch_if_int_pin_high <= spfa_pkg::RST_BIT;
      o_branch_if_int_pin_low  <= spfa_pkg::RST_BIT;
      o_ext_int_pullup         <= spfa_pkg::RST_BIT;
      o_ext_int_pulldown       <= spfa_pkg::RST_BIT;
    end else begin
      o_ext_int_req_level      <= ext_en && ext_s2;
      o_branch_if_int_pin_high <= ext_en && ext_s2;
      o_branch_if_int_pin_low  <= ext_en && !ext_s2;
      o_ext_int_pullup         <= next_ext_pullup;
      o_ext_int_pulldown       <= next_ext_pulldown;
    end
  end

  // Reset leaves buffers off and pulls off
  property p_reset_state;
    @(posedge i_core_clk)
    $past(i_sys_rst) |->
      (o_pad_oe_n == spfa_pkg::RST_PAD_OE_N) && (o_pad_pullup == spfa_pkg::RST_ZERO) &&
      (o_pad_pulldown == spfa_pkg::RST_ZERO);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("pads not released to unpulled inputs at reset");

  // Reset leaves the interrupt pin silent and unpulled
  property p_reset_ext;
    @(posedge i_core_clk)
    $past(i_sys_rst) |->
      !o_ext_int_req_level && !o_ext_int_pullup && !o_ext_int_pulldown &&
      !o_branch_if_int_pin_high && !o_branch_if_int_pin_low;
  endproperty
  a_reset_ext: assert property (p_reset_ext)
    else $error("interrupt pin active straight after reset");

  // Branch conditions follow the pad three cycles later while enabled
  property p_branch_route;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ($past(ext_en) && !$past(i_sys_rst, 3)) |->
      (o_branch_if_int_pin_high == $past(i_ext_int_pad, 3)) &&
      (o_branch_if_int_pin_low == !$past(i_ext_int_pad, 3)) &&
      (o_ext_int_req_level == o_branch_if_int_pin_high);
  endproperty
  a_branch_route: assert property (p_branch_route)
    else $error("interrupt pin level not routed to branch conditions");

  // Disabled pin is silent
  property p_ext_disabled;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !ext_en |=> !o_ext_int_req_level && !o_branch_if_int_pin_high &&
                !o_branch_if_int_pin_low && !o_ext_int_pullup && !o_ext_int_pulldown;
  endproperty
  a_ext_disabled: assert property (p_ext_disabled)
    else $error("disabled interrupt pin still active");

  // Rising sense uses the pulldown
  property p_ext_rise_pull;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (ext_en && ext_pull) |=> (o_ext_int_pulldown == $past(ext_rise)) &&
                             (o_ext_int_pullup == !$past(ext_rise));
  endproperty
  a_ext_rise_pull: assert property (p_ext_rise_pull)
    else $error("interrupt pin pull direction wrong for edge sense");

  // Port read value under any ownership
  property p_port_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && (i_reg_addr == spfa_pkg::OFF_PORT_DATA)) |=>
      o_reg_rdata == (($past(port_dir) & $past(port_data)) |
                      (~$past(port_dir) & $past(pad_s2)));
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port data read ignores direction bits");

  // Per-pad ownership, direction and pull checks
  generate
    for (g = 0; g < spfa_pkg::NUM_PADS; g++) begin : g_chk
      property p_hi_owner;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_alt_hi_en[g] |=> (o_pad_oe_n[g] == !$past(i_alt_hi_oe[g])) &&
                           (o_pad_out[g] == $past(i_alt_hi_out[g]));
      endproperty
      a_hi_owner: assert property (p_hi_owner)
        else $error("higher priority function lost the pad");

      property p_lo_owner;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_alt_lo_en[g] && !i_alt_hi_en[g]) |=> o_pad_oe_n[g] == !$past(i_alt_lo_oe[g]);
      endproperty
      a_lo_owner: assert property (p_lo_owner)
        else $error("owning peripheral does not set pad direction");

      property p_port_owner;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (!i_alt_lo_en[g] && !i_alt_hi_en[g]) |=>
          (o_pad_oe_n[g] == !$past(port_dir[g])) && (o_pad_out[g] == $past(port_data[g]));
      endproperty
      a_port_owner: assert property (p_port_owner)
        else $error("port control not used on a free pad");

      property p_input_pull;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_pad_oe_n[g] |-> ((o_pad_pullup[g] || o_pad_pulldown[g]) == $past(pull_en[g]));
      endproperty
      a_input_pull: assert property (p_input_pull)
        else $error("pull enable not applied to input pad");

      property p_keypad_pull;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (spfa_pkg::KEYPAD_PAD_MASK[g] && i_alt_lo_en[g] && !i_alt_hi_en[g] &&
         !i_alt_lo_oe[g] && pull_en[g] && i_keypad_rise_sense[g]) |=>
          o_pad_pulldown[g] && !o_pad_pullup[g];
      endproperty
      a_keypad_pull: assert property (p_keypad_pull)
        else $error("keypad rising sense did not select pulldown");

      // Never both pulls at once, and pulldowns only on keypad pads
      property p_pull_exclusive;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !(o_pad_pullup[g] && o_pad_pulldown[g]) &&
        (spfa_pkg::KEYPAD_PAD_MASK[g] || !o_pad_pulldown[g]);
      endproperty
      a_pull_exclusive: assert property (p_pull_exclusive)
        else $error("pad pull selection conflicting or on a non-keypad pad");
    end
  endgenerate

endmodule

/* File: bench/spfa_periph_model.sv */
// Peripheral and pad environment model facing the pin arbiter
`timescale 1ns/10ps
module spfa_periph_model (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // Requested lo en, oe, out, sense and hi en, oe, out
  input  wire logic [55:0] i_req,
  // External drivers on the pads
  input  wire logic [7:0]  i_ext_drv,
  input  wire logic [7:0]  i_ext_val,
  // Pad controls from the arbiter
  input  wire logic [7:0]  i_pad_out,
  input  wire logic [7:0]  i_pad_oe_n,
  input  wire logic [7:0]  i_pad_pullup,
  input  wire logic [7:0]  i_pad_pulldown,
  // Peripheral signals to the arbiter
  output logic      [7:0]  o_alt_lo_en,
  output logic      [7:0]  o_alt_lo_oe,
  output logic      [7:0]  o_alt_lo_out,
  output logic      [7:0]  o_keypad_rise_sense,
  output logic      [7:0]  o_alt_hi_en,
  output logic      [7:0]  o_alt_hi_oe,
  output logic      [7:0]  o_alt_hi_out,
  // Resolved pad levels
  output logic      [7:0]  o_pad_in
);
  logic [55:0] cur;
  logic        gap;
  logic [7:0]  float_pat;
  logic [55:0] en_mask;

  // Any change passes through one cycle with every function disabled
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cur       <= 56'h0;
      gap       <= 1'b0;
      float_pat <= 8'h5a;
    end else begin
      gap       <= (i_req != cur);
      cur       <= i_req;
      float_pat <= ~float_pat;
    end
  end

  // Enables held off during the quiet cycle; oe, out and sense pass through unmasked
  assign en_mask = {{8{~gap}}, 24'hffffff, {8{~gap}}, 16'hffff};
  assign {o_alt_lo_en, o_alt_lo_oe, o_alt_lo_out, o_keypad_rise_sense,
          o_alt_hi_en, o_alt_hi_oe, o_alt_hi_out} = cur & en_mask;
  // Undriven pads without pull toggle so a stale level never matches by luck
  assign o_pad_in = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & i_ext_drv & i_ext_val)
                  | (i_pad_oe_n & ~i_ext_drv & (i_pad_pullup | (~i_pad_pulldown & float_pat)));
endmodule

/* File: bench/spfa_top_tb.sv */
// Self-checking testbench for the shared pin function arbiter
`timescale 1ns/10ps
module spfa_top_tb;
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        ext_pad   = 1'b0;
  logic [55:0] r_req     = 56'h0;
  logic [7:0]  r_drv     = 8'h00;
  logic [7:0]  r_val     = 8'h00;
  logic [7:0]  cfg [13];
  int          seed      = 32'h9d7e955a;
  int          n_errors  = 0;
  int          checks_done = 0;
  logic [7:0]  rdata, pad_in, pad_out, oe_n, pu, pd, level, lo_en, lo_oe, lo_out;
  logic [7:0]  sense, hi_en, hi_oe, hi_out;
  logic        req_lvl, br_hi, br_lo, x_pu, x_pd;

  // Named views of the current configuration
  wire [7:0] c_dir = cfg[0];
  wire [7:0] c_data = cfg[1];
  wire [7:0] c_pull = cfg[2];
  wire [7:0] c_ext = cfg[3];
  wire [7:0] c_lo_en = cfg[4];
  wire [7:0] c_lo_oe = cfg[5];
  wire [7:0] c_lo_out = cfg[6];
  wire [7:0] c_sense = cfg[7];
  wire [7:0] c_hi_en = cfg[8];
  wire [7:0] c_hi_oe = cfg[9];
  wire [7:0] c_hi_out = cfg[10];
  wire       c_xpad = cfg[3][7];
  wire       c_en = cfg[3][spfa_pkg::EXT_EN_BIT];

  // Clock
  always #5 core_clk = ~core_clk;

  spfa_top spfa_top_inst (
    .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe_n(oe_n), .o_pad_pullup(pu),
    .o_pad_pulldown(pd), .i_alt_lo_en(lo_en), .i_alt_lo_oe(lo_oe), .i_alt_lo_out(lo_out),
    .i_keypad_rise_sense(sense), .i_alt_hi_en(hi_en), .i_alt_hi_oe(hi_oe),
    .i_alt_hi_out(hi_out), .o_pad_level(level), .i_ext_int_pad(ext_pad),
    .o_ext_int_req_level(req_lvl), .o_branch_if_int_pin_high(br_hi),
    .o_branch_if_int_pin_low(br_lo), .o_ext_int_pullup(x_pu), .o_ext_int_pulldown(x_pd));

  spfa_periph_model spfa_periph_model_inst (
    .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_req(r_req), .i_ext_drv(r_drv),
    .i_ext_val(r_val), .i_pad_out(pad_out), .i_pad_oe_n(oe_n), .i_pad_pullup(pu),
    .i_pad_pulldown(pd), .o_alt_lo_en(lo_en), .o_alt_lo_oe(lo_oe), .o_alt_lo_out(lo_out),
    .o_keypad_rise_sense(sense), .o_alt_hi_en(hi_en), .o_alt_hi_oe(hi_oe),
    .o_alt_hi_out(hi_out), .o_pad_in(pad_in));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data is taken in the one cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction

  // Expected drive, out, pullup, pulldown and known-level mask per pad
  function automatic logic [39:0] exp_pads();
    logic [7:0] lo, port, drv, out, epd, epu;
    lo   = c_lo_en & ~c_hi_en;
    port = ~c_hi_en & ~c_lo_en;
    drv  = (c_hi_en & c_hi_oe) | (lo & c_lo_oe) | (port & c_dir);
    out  = (c_hi_en & c_hi_out) | (lo & c_lo_out) | (port & c_data);
    epd  = ~drv & c_pull & lo & c_sense & spfa_pkg::KEYPAD_PAD_MASK;
    epu  = ~drv & c_pull & ~epd;
    return {drv, out, epu, epd, drv | cfg[11] | epu | epd};
  endfunction

  task automatic check_all();
    logic [39:0] e;
    logic [7:0]  pad, k, rd;
    e   = exp_pads();
    k   = e[7:0];
    pad = (e[39:32] & e[31:24]) | (~e[39:32] & cfg[11] & cfg[12]) | (~e[39:32] & ~cfg[11] & e[23:16]);
    cmp(oe_n, ~e[39:32]);
    cmp(pad_out, e[31:24]);
    cmp(pu, e[23:16]);
    cmp(pd, e[15:8]);
    cmp(level & k, pad & k);
    bus_rd(spfa_pkg::OFF_PORT_DATA, rd);
    cmp(rd & (c_dir | k), (c_dir & c_data) | (~c_dir & pad & k));
    bus_rd(spfa_pkg::OFF_OWNER_LO, rd);
    cmp(rd, c_lo_en & ~c_hi_en);
    bus_rd(spfa_pkg::OFF_OWNER_HI, rd);
    cmp(rd, c_hi_en);
    bus_rd(spfa_pkg::OFF_EXT_INT_CTRL, rd);
    cmp(rd, c_ext & spfa_pkg::EXT_CTRL_MASK);
    bus_rd(4'h9, rd);
    cmp(rd, 8'h00);
    cmp_bit(req_lvl, c_en & c_xpad);
    cmp_bit(br_hi, c_en & c_xpad);
    cmp_bit(br_lo, c_en & ~c_xpad);
    cmp_bit(x_pu, c_en & c_ext[2] & ~c_ext[1]);
    cmp_bit(x_pd, c_en & c_ext[2] & c_ext[1]);
  endtask

  task automatic apply();
    bus_wr(spfa_pkg::OFF_PORT_DATA, c_data);
    bus_wr(spfa_pkg::OFF_PORT_DIR, c_dir);
    bus_wr(spfa_pkg::OFF_PULL_EN, c_pull);
    bus_wr(spfa_pkg::OFF_EXT_INT_CTRL, c_ext);
    @(posedge core_clk);
    r_req   <= {c_lo_en, c_lo_oe, c_lo_out, c_sense, c_hi_en, c_hi_oe, c_hi_out};
    r_drv   <= cfg[11];
    r_val   <= cfg[12];
    ext_pad <= c_xpad;
    repeat (8) @(posedge core_clk);
    #1;
    check_all();
  endtask

  task automatic print_verdict();
    $display("Errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end

  // Main sequence: reset values, corner cases, then random configurations
  initial begin
    for (int k = 0; k < 13; k++) cfg[k] = 8'h00;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    cmp(oe_n, spfa_pkg::RST_PAD_OE_N);
    cmp(pu | pd, 8'h00);
    check_all();
    for (int i = 0; i < 60; i++) begin
      for (int k = 0; k < 13; k++) cfg[k] = rnd8();
      case (i)
        0: cfg = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h33, 8'hff, 8'hff, 8'h0f, 8'hcc, 8'h00, 8'h00};
        1: cfg = '{8'h00, 8'h00, 8'hff, 8'h07, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        2: cfg = '{8'haa, 8'h5a, 8'hff, 8'h85, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        3: cfg = '{8'h0f, 8'hff, 8'h00, 8'h86, 8'hf0, 8'hf0, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h3c};
        4: cfg = '{8'hff, 8'hc3, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        default: ;
      endcase
      apply();
    end
    bus_wr(spfa_pkg::OFF_OWNER_HI, 8'hff);
    bus_wr(4'h9, 8'hff);
    check_all();
    print_verdict();
  end
endmodule
